// >>> tb_top.sv
// Self-checking testbench for the transmit interpolation and mix path.
`timescale 1ns/100ps
`include "txp_consts.svh"
module tb_top;
  logic                  sys_clk     = 1'b0;
  logic                  resetn      = 1'b0;
  logic [3:0]            reg_addr    = 4'h0;
  logic [7:0]            reg_wr_data = 8'h00;
  logic                  reg_wr      = 1'b0;
  logic                  reg_rd      = 1'b0;
  logic                  run         = 1'b0;
  logic                  use_b       = 1'b0;
  logic                  dual        = 1'b0;
  logic [`TXP_PIN_W-1:0] word_a      = 14'h0100;
  logic [`TXP_PIN_W-1:0] word_b      = 14'h0000;
  logic [7:0]            reg_rd_data;
  txp_pkg::txp_sample_t  dac_a_data;
  txp_pkg::txp_sample_t  dac_b_data;
  logic                  dac_update;
  logic                  dac_b_enable;
  logic                  lclk_a;
  logic                  lclk_b;
  logic                  tx_is_b;
  logic [`TXP_PIN_W-1:0] tx_data;
  txp_pkg::txp_sample_t  smp [0:4];
  int                    n_fail      = 0;
  int                    num_checks  = 0;
  int                    cycles      = 0;
  int                    pulses      = 0;
  txp_path dut (.sys_clk, .resetn, .sample_latch_clock_a(lclk_a),
    .sample_latch_clock_b(lclk_b), .tx_data, .tx_data_is_b(tx_is_b),
    .reg_addr, .reg_wr_data, .reg_wr, .reg_rd, .reg_rd_data, .dac_a_data,
    .dac_b_data, .dac_update, .dac_b_enable);
  txp_src_model src (.run, .use_b, .dual, .word_a, .word_b, .clk_a(lclk_a),
    .clk_b(lclk_b), .data(tx_data), .is_b(tx_is_b));
  always #2 sys_clk = ~sys_clk;
  // The whole run needs about 2700 cycles; the ceiling leaves wide margin.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (dac_update === 1'b1) pulses <= pulses + 1;
    if (cycles == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_wr      <= 1'b1;
    reg_addr    <= a;
    reg_wr_data <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_check(string what, logic [3:0] a, logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check(what, {8'h00, exp}, {8'h00, reg_rd_data});
  endtask
  task automatic stream(logic [7:0] mode, logic [1:0] f, logic [7:0] dsp);
    wr(`TXP_REG_MODE, mode);
    wr(`TXP_REG_INTERP, {6'h00, f});
    wr(`TXP_REG_DSP, dsp);
    dual  <= mode[1:0] != 2'h0;
    use_b <= mode[2];
    run   <= 1'b1;
    repeat (4) @(posedge lclk_a or posedge lclk_b);
  endtask
  task automatic grab();
    for (int k = 0; k < 5; k++) begin
      @(negedge sys_clk);
      while (dac_update !== 1'b1) @(negedge sys_clk);
      smp[k] = dac_a_data;
    end
  endtask
  task automatic t_regs();
    rd_check("interp", `TXP_REG_INTERP, `TXP_RST_INTERP);
    rd_check("mode", `TXP_REG_MODE, `TXP_RST_MODE);
    rd_check("dsp", `TXP_REG_DSP, `TXP_RST_DSP);
    for (int k = 0; k < 3; k++) begin
      rd_check("tw reset", 4'(`TXP_REG_TW0 + k), 8'h00);
      wr(4'(`TXP_REG_TW0 + k), 8'hA5 ^ 8'(k));
      rd_check("tw", 4'(`TXP_REG_TW0 + k), 8'hA5 ^ 8'(k));
    end
    wr(`TXP_REG_INTERP, 8'hFF);
    rd_check("interp field", `TXP_REG_INTERP, 8'h03);
    wr(4'hA, 8'h55);
    rd_check("unmapped", 4'hA, 8'h00);
  endtask
  task automatic t_stat();
    logic [31:0] tbl [7] = '{32'h08020D1F, 32'h08010D01, 32'h08020C01,
      32'h09020D00, 32'h0A020C1C, 32'h0A018C08, 32'h0802031B};
    for (int k = 0; k < 7; k++) begin
      wr(`TXP_REG_MODE, tbl[k][31:24]);
      wr(`TXP_REG_INTERP, tbl[k][23:16]);
      wr(`TXP_REG_DSP, tbl[k][15:8]);
      rd_check("status", `TXP_REG_STAT, tbl[k][7:0]);
    end
  endtask
  task automatic t_rate();
    int p0;
    for (int f = 0; f < 3; f++) begin
      stream(8'h08, 2'(f), 8'h00);
      p0 = pulses;
      repeat (8) @(posedge lclk_a);
      check("updates", 16'(8 << f), 16'(pulses - p0));
    end
    // Rising and falling capture together give two events per period.
    stream(8'h18, 2'h0, 8'h00);
    p0 = pulses;
    repeat (8) @(posedge lclk_a);
    check("both edges", 16'h0010, 16'(pulses - p0));
  endtask
  task automatic t_pass();
    txp_pkg::txp_sample_t v;
    stream(8'h08, 2'h0, 8'h00);
    v = dac_a_data;
    word_a <= 14'h3F00;
    repeat (3) @(posedge lclk_a);
    check("bypass sign", 16'(-v), dac_a_data);
    check("bypass zero", 16'h0000, 16'(v == 16'sh0000));
  endtask
  task automatic t_coarse();
    stream(8'h08, 2'h0, 8'h10);
    grab();
    check("quarter even", 16'(-smp[0]), smp[2]);
    check("quarter odd", 16'(-smp[1]), smp[3]);
    check("quarter moves", 16'h0000, 16'(smp[0] == smp[1]));
    stream(8'h08, 2'h0, 8'h20);
    grab();
    check("eighth", 16'h0001, 16'(smp[0] + smp[4] inside {[-1:1]}));
  endtask
  task automatic t_dual();
    word_a <= 14'h0000;
    word_b <= 14'h0200;
    stream(8'h0D, 2'h0, 8'h00);
    check("b enable", 16'h0001, 16'(dac_b_enable));
    check("a alone", 16'h0000, dac_a_data);
    check("b moves", 16'h0000, 16'(dac_b_data == 16'sh0000));
    stream(8'h08, 2'h0, 8'h00);
    check("b off", 16'h0000, 16'(dac_b_enable));
    check("b quiet", 16'h0000, dac_b_data);
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    t_regs();
    t_stat();
    t_rate();
    t_pass();
    t_coarse();
    t_dual();
    stop_test();
  end
endmodule

// >>> txp_consts.svh
// Constants for the transmit interpolation and modulation path.
// Overview of operation
// RULE1 - Bypass, 2x or 4x from two halfband stages.
// RULE2 - First stage: 39 taps, 60 dB rejection.
// RULE3 - Source keeps 2x input at 64 MSPS.
// RULE4 - Second stage: 15 taps, 60 dB, flat passband.
// RULE5 - Source keeps 4x input at 32 MSPS.
// RULE6 - 24-bit oscillator mixes I and Q complexly.
// RULE7 - Oscillator mix works only with 4x interpolation.
// RULE8 - Tunes to quarter rate, step rate/2^26.
// RULE9 - Oscillator mix precedes the interpolation filters.
// RULE10 - Mix off at reset, two path bits enable.
// RULE11 - Hilbert makes I/Q, needs 4x, 32 MSPS.
// RULE12 - Sideband select keeps upper or lower image.
// RULE13 - Latch single or dual words, chosen edges.
// RULE14 - Single mode drives channel A, B off.
// RULE15 - Single mode allows all blocks, bypass fastest.
// RULE16 - Coarse shift quarter/eighth, real or complex.
// RULE17 - Single mode mix needs 4x and Hilbert.
// RULE18 - Dual real: independent channels, interp, coarse.
// RULE19 - Interface 128 MSPS, 64 per channel.
// RULE20 - Prefer 4x at 32 MSPS per channel.
// RULE21 - Dual real coarse mix per channel.
// RULE22 - Coarse off at reset, real/complex select.
// RULE23 - Phase accumulator addresses sine and cosine.
// RULE24 - Symmetric designer-chosen lowpass coefficient sets.
`ifndef TXP_CONSTS_SVH
`define TXP_CONSTS_SVH
`define TXP_REG_INTERP     4'h0
`define TXP_REG_MODE       4'h1
`define TXP_REG_DSP        4'h2
`define TXP_REG_TW0        4'h3
`define TXP_REG_TW1        4'h4
`define TXP_REG_TW2        4'h5
`define TXP_REG_STAT       4'h6
`define TXP_REG_COUNT      4'h7
`define TXP_INTERP_2X      2'h1
`define TXP_INTERP_4X      2'h2
`define TXP_MODE_SINGLE    2'h0
`define TXP_MODE_COMPLEX   2'h2
`define TXP_COARSE_OFF     2'h0
`define TXP_COARSE_QUARTER 2'h1
`define TXP_RST_INTERP     8'h00
`define TXP_RST_MODE       8'h08
`define TXP_RST_DSP        8'h00
`define TXP_Q14_SHIFT      14
`define TXP_QUARTER_TURN   6'h10
`define TXP_EIGHTH_STEP    6'h08
`define TXP_SIN_QUARTER    16
`define TXP_SAT_MAX        32'sh00007FFF
`define TXP_SAT_MIN        32'shFFFF8000
`define TXP_PIN_W          14
`define TXP_PER_W          12
`define TXP_FIR1_TAPS      39
`define TXP_FIR2_TAPS      15
`define TXP_HIL_TAPS       11
`define TXP_FIR1_LEN       ((`TXP_FIR1_TAPS + 1) / 2)
`define TXP_FIR2_LEN       ((`TXP_FIR2_TAPS + 1) / 2)
`endif

// >>> txp_path.sv
// Transmit path: latch, Hilbert, oscillator mix, interpolation, coarse mix.
`timescale 1ns/100ps
`include "txp_consts.svh"
module txp_path (
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic                  sample_latch_clock_a,
  input  wire logic                  sample_latch_clock_b,
  input  wire logic [`TXP_PIN_W-1:0] tx_data,
  input  wire logic                  tx_data_is_b,
  input  wire logic [3:0]            reg_addr,
  input  wire logic [7:0]            reg_wr_data,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [7:0]                 reg_rd_data,
  output txp_pkg::txp_sample_t       dac_a_data,
  output txp_pkg::txp_sample_t       dac_b_data,
  output logic                       dac_update,
  output logic                       dac_b_enable
);
  localparam int P1 = `TXP_FIR1_LEN / 2;
  localparam int P2 = `TXP_FIR2_LEN / 2;
  localparam int HC = (`TXP_HIL_TAPS - 1) / 2;
  localparam int HP = (HC + 1) / 2;
  // Halfband odd-phase taps; even phase is the bare centre sample.
  localparam int FIR1_C [P1] = '{10200, -3200, 1700, -1000, 620,
                                 -380, 220, -115, 50, -15}; // RULE24
  localparam int FIR2_C [P2] = '{9800, -2400, 780, -180}; // RULE24
  localparam int HIL_C [HP] = '{10126, 2950, 1215};
  localparam int SIN_TBL [`TXP_SIN_QUARTER + 1] = '{0, 1606, 3196, 4756,
    6270, 7723, 9102, 10394, 11585, 12665, 13623, 14449, 15137, 15679,
    16069, 16305, 16384};

  txp_pkg::txp_state_s st_r;
  txp_pkg::txp_state_s st_nxt;

  function automatic txp_pkg::txp_sample_t sat16(input int v);
    if (v > `TXP_SAT_MAX) begin
      return 16'sh7FFF;
    end else if (v < `TXP_SAT_MIN) begin
      return 16'sh8000;
    end
    return txp_pkg::txp_sample_t'(v);
  endfunction

  function automatic txp_pkg::txp_sample_t mulq(
    input txp_pkg::txp_sample_t a,
    input txp_pkg::txp_sample_t c
  );
    return sat16((int'(a) * int'(c)) >>> `TXP_Q14_SHIFT);
  endfunction

  function automatic txp_pkg::txp_iq_s cmix(
    input txp_pkg::txp_iq_s     x,
    input txp_pkg::txp_sample_t c,
    input txp_pkg::txp_sample_t s
  );
    txp_pkg::txp_iq_s r;
    r.i = sat16((int'(x.i) * int'(c) - int'(x.q) * int'(s))
                >>> `TXP_Q14_SHIFT);
    r.q = sat16((int'(x.i) * int'(s) + int'(x.q) * int'(c))
                >>> `TXP_Q14_SHIFT);
    return r;
  endfunction

  // Quarter-wave table keeps the lookup small at some phase resolution.
  function automatic txp_pkg::txp_sample_t sin_q(
    input txp_pkg::txp_phase_s p
  );
    int v;
    v = p.quad[0] ? SIN_TBL[`TXP_SIN_QUARTER - int'(p.idx)]
                  : SIN_TBL[int'(p.idx)];
    if (p.quad[1]) begin
      v = -v;
    end
    return txp_pkg::txp_sample_t'(v);
  endfunction

  function automatic txp_pkg::txp_sample_t fir1_odd(
    input txp_pkg::txp_sample_t [`TXP_FIR1_LEN-1:0] h
  );
    int acc;
    acc = 0;
    for (int j = 0; j < P1; j++) begin
      acc += FIR1_C[j] * (int'(h[P1-1-j]) + int'(h[P1+j])); // RULE2
    end
    return sat16(acc >>> `TXP_Q14_SHIFT);
  endfunction

  function automatic txp_pkg::txp_sample_t fir2_odd(
    input txp_pkg::txp_sample_t [`TXP_FIR2_LEN-1:0] h
  );
    int acc;
    acc = 0;
    for (int j = 0; j < P2; j++) begin
      acc += FIR2_C[j] * (int'(h[P2-1-j]) + int'(h[P2+j])); // RULE4
    end
    return sat16(acc >>> `TXP_Q14_SHIFT);
  endfunction

  function automatic txp_pkg::txp_sample_t hil_q(
    input txp_pkg::txp_sample_t [`TXP_HIL_TAPS-1:0] h
  );
    int acc;
    acc = 0;
    for (int j = 0; j < HP; j++) begin
      acc += HIL_C[j] * (int'(h[HC-1-2*j]) - int'(h[HC+1+2*j])); // RULE11
    end
    return sat16(acc >>> `TXP_Q14_SHIFT);
  endfunction

  always_comb begin
    txp_pkg::txp_stat_s    stat;
    txp_pkg::txp_iq_s      pre;
    txp_pkg::txp_iq_s      post;
    txp_pkg::txp_iq_s      filt;
    txp_pkg::txp_iq_s      mixed;
    txp_pkg::txp_phase_s   cph;
    txp_pkg::txp_sample_t  word;
    txp_pkg::txp_sample_t  ch_a;
    txp_pkg::txp_sample_t  ch_b;
    txp_pkg::txp_sample_t  qsum;
    txp_pkg::txp_sample_t  cc;
    txp_pkg::txp_sample_t  cs;
    txp_pkg::txp_sample_t  e1i;
    txp_pkg::txp_sample_t  e1q;
    txp_pkg::txp_sample_t  o1i;
    txp_pkg::txp_sample_t  o1q;
    logic [1:0]            sh;
    logic [1:0]            last;
    logic [5:0]            cstep;
    logic                  lnow;
    logic                  lold;
    logic                  cap;
    logic                  ev;
    logic                  fire;
    // Every local gets a value first, so no path can infer a latch.
    stat = '0;
    pre = '0;
    post = '0;
    filt = '0;
    mixed = '0;
    cph = '0;
    word = '0;
    ch_a = '0;
    ch_b = '0;
    qsum = '0;
    cc = '0;
    cs = '0;
    sh = 2'h0;
    last = 2'h0;
    cstep = '0;
    e1i = '0;
    e1q = '0;
    o1i = '0;
    o1q = '0;
    lnow = 1'b0;
    lold = 1'b0;
    cap = 1'b0;
    ev = 1'b0;
    fire = 1'b0;
    st_nxt = st_r;
    // Clock, data and channel marker take the same two-stage delay.
    st_nxt.lclk_m = {sample_latch_clock_b, sample_latch_clock_a};
    st_nxt.lclk_s = st_r.lclk_m;
    st_nxt.lclk_d = st_r.lclk_s;
    st_nxt.din_m = tx_data;
    st_nxt.din_s = st_r.din_m;
    st_nxt.selb_m = tx_data_is_b;
    st_nxt.selb_s = st_r.selb_m;

    // Effective enables: illegal combinations turn the block off; complex coarse mix without I/Q falls back to real.
    stat.single = (st_r.mode_r.mode == `TXP_MODE_SINGLE); // RULE15
    stat.hil_on = stat.single && st_r.dsp_r.hilbert &&
                  (st_r.interp_r.interp == `TXP_INTERP_4X); // RULE11
    stat.iq = (st_r.mode_r.mode == `TXP_MODE_COMPLEX) || stat.hil_on;
    stat.fine_on = st_r.dsp_r.fine_a && st_r.dsp_r.fine_b && stat.iq &&
                   (st_r.interp_r.interp == `TXP_INTERP_4X); // RULE7 RULE10 RULE17 RULE18
    stat.coarse_cplx = stat.iq && !st_r.dsp_r.real_mix; // RULE22

    lnow = st_r.mode_r.clk_b ? st_r.lclk_s[1] : st_r.lclk_s[0];
    lold = st_r.mode_r.clk_b ? st_r.lclk_d[1] : st_r.lclk_d[0];
    cap = (st_r.mode_r.rise && lnow && !lold) ||
          (st_r.mode_r.fall && !lnow && lold); // RULE13
    word = txp_pkg::txp_sample_t'($signed(st_r.din_s));
    ch_a = stat.single ? word : st_r.hold_a;
    ch_b = stat.single ? '0 : word; // RULE14
    ev = cap && (stat.single || st_r.selb_s); // RULE13 RULE19
    if (cap && !stat.single && !st_r.selb_s) begin
      st_nxt.hold_a = word;
    end

    qsum = hil_q(st_r.hil);
    pre.i = stat.hil_on ? st_r.hil[HC] : ch_a;
    pre.q = ch_b;
    if (stat.hil_on) begin
      pre.q = st_r.dsp_r.sideband_select_low ? sat16(-int'(qsum))
                                             : qsum; // RULE12
    end
    post = pre;
    if (stat.fine_on) begin
      post = cmix(pre, sin_q(st_r.acc.ph + `TXP_QUARTER_TURN),
                  sin_q(st_r.acc.ph)); // RULE6 RULE9 RULE23
    end

    if (st_r.per_cnt != '1) begin
      st_nxt.per_cnt = st_r.per_cnt + 1'b1;
    end
    if (st_r.interp_r.interp == `TXP_INTERP_2X) begin
      sh = 2'h1;
      last = 2'h1;
    end else if (st_r.interp_r.interp == `TXP_INTERP_4X) begin
      sh = 2'h2;
      last = 2'h3;
    end
    // A new event restarts the slots, so a source that runs too fast
    // loses the tail of each interpolated group.
    fire = (st_r.run == txp_pkg::TXP_RUN) && (st_r.tmr == '0);
    if (st_r.run == txp_pkg::TXP_RUN) begin
      if (fire) begin
        st_nxt.tmr = st_r.step - 1'b1;
        st_nxt.slot = st_r.slot + 2'h1;
        if (st_r.slot == last) begin
          st_nxt.run = txp_pkg::TXP_IDLE;
        end
      end else begin
        st_nxt.tmr = st_r.tmr - 1'b1;
      end
    end
    if (ev) begin
      // Output slots spread evenly over the last measured input period.
      st_nxt.step = st_r.per_cnt >> sh;
      if (st_nxt.step == '0) begin
        st_nxt.step = {{(`TXP_PER_W-1){1'b0}}, 1'b1};
      end
      st_nxt.per_cnt = {{(`TXP_PER_W-1){1'b0}}, 1'b1};
      st_nxt.tmr = '0;
      st_nxt.slot = 2'h0;
      st_nxt.run = txp_pkg::TXP_RUN;
      st_nxt.count = st_r.count + 8'h01;
      st_nxt.hil = {st_r.hil[`TXP_HIL_TAPS-2:0], ch_a};
      st_nxt.hist1_i = {st_r.hist1_i[`TXP_FIR1_LEN-2:0], post.i};
      st_nxt.hist1_q = {st_r.hist1_q[`TXP_FIR1_LEN-2:0], post.q};
      st_nxt.acc = st_r.acc + st_r.nco_tuning_word; // RULE8 RULE23
    end

    e1i = st_r.hist1_i[P1];
    e1q = st_r.hist1_q[P1];
    o1i = fir1_odd(st_r.hist1_i);
    o1q = fir1_odd(st_r.hist1_q);
    filt.i = st_r.hist1_i[0]; // RULE15
    filt.q = st_r.hist1_q[0];
    if (st_r.interp_r.interp == `TXP_INTERP_2X) begin
      filt.i = st_r.slot[0] ? o1i : e1i; // RULE1
      filt.q = st_r.slot[0] ? o1q : e1q;
    end else if (st_r.interp_r.interp == `TXP_INTERP_4X) begin
      filt.i = st_r.slot[0] ? fir2_odd(st_r.hist2_i) : st_r.hist2_i[P2]; // RULE1
      filt.q = st_r.slot[0] ? fir2_odd(st_r.hist2_q) : st_r.hist2_q[P2];
      if (fire && st_r.slot[0]) begin
        st_nxt.hist2_i = {st_r.hist2_i[`TXP_FIR2_LEN-2:0],
                          st_r.slot[1] ? o1i : e1i};
        st_nxt.hist2_q = {st_r.hist2_q[`TXP_FIR2_LEN-2:0],
                          st_r.slot[1] ? o1q : e1q};
      end
    end

    cstep = (st_r.dsp_r.coarse == `TXP_COARSE_QUARTER) ? `TXP_QUARTER_TURN
                                                     : `TXP_EIGHTH_STEP;
    cph = 6'({3'h0, st_r.cn} * cstep);
    cc = sin_q(cph + `TXP_QUARTER_TURN);
    cs = st_r.dsp_r.coarse_neg ? sat16(-int'(sin_q(cph))) : sin_q(cph);
    mixed = filt;
    if (st_r.dsp_r.coarse != `TXP_COARSE_OFF) begin
      if (stat.coarse_cplx) begin
        mixed = cmix(filt, cc, cs); // RULE16
      end else begin
        mixed.i = mulq(filt.i, cc); // RULE16 RULE21
        mixed.q = mulq(filt.q, cc);
      end
    end
    st_nxt.dac_upd = fire;
    if (fire) begin
      st_nxt.cn = st_r.cn + 3'h1;
      st_nxt.dac_a = mixed.i;
      st_nxt.dac_b = stat.single ? '0 : mixed.q; // RULE14
    end
    st_nxt.dac_b_en = !stat.single; // RULE14

    // Reserved bits are cleared on write so reads never show stale bits.
    if (reg_wr) begin
      if (reg_addr == `TXP_REG_INTERP) begin
        st_nxt.interp_r = reg_wr_data;
        st_nxt.interp_r.rsv = '0;
      end else if (reg_addr == `TXP_REG_MODE) begin
        st_nxt.mode_r = reg_wr_data;
        st_nxt.mode_r.rsv = '0;
      end else if (reg_addr == `TXP_REG_DSP) begin
        st_nxt.dsp_r = reg_wr_data; // RULE10 RULE22
      end else if (reg_addr == `TXP_REG_TW0) begin
        st_nxt.nco_tuning_word.lo = reg_wr_data;
      end else if (reg_addr == `TXP_REG_TW1) begin
        st_nxt.nco_tuning_word.mid = reg_wr_data;
      end else if (reg_addr == `TXP_REG_TW2) begin
        st_nxt.nco_tuning_word.hi = reg_wr_data;
      end
    end
    st_nxt.rd_data = 8'h00;
    if (reg_rd) begin
      if (reg_addr == `TXP_REG_INTERP) begin
        st_nxt.rd_data = st_r.interp_r;
      end else if (reg_addr == `TXP_REG_MODE) begin
        st_nxt.rd_data = st_r.mode_r;
      end else if (reg_addr == `TXP_REG_DSP) begin
        st_nxt.rd_data = st_r.dsp_r;
      end else if (reg_addr == `TXP_REG_TW0) begin
        st_nxt.rd_data = st_r.nco_tuning_word.lo;
      end else if (reg_addr == `TXP_REG_TW1) begin
        st_nxt.rd_data = st_r.nco_tuning_word.mid;
      end else if (reg_addr == `TXP_REG_TW2) begin
        st_nxt.rd_data = st_r.nco_tuning_word.hi;
      end else if (reg_addr == `TXP_REG_STAT) begin
        st_nxt.rd_data = stat;
      end else if (reg_addr == `TXP_REG_COUNT) begin
        st_nxt.rd_data = st_r.count;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
      st_r.interp_r <= `TXP_RST_INTERP;
      st_r.mode_r <= `TXP_RST_MODE;
      st_r.dsp_r <= `TXP_RST_DSP; // RULE10 RULE22
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rd_data = st_r.rd_data;
  assign dac_a_data = st_r.dac_a;
  assign dac_b_data = st_r.dac_b;
  assign dac_update = st_r.dac_upd;
  assign dac_b_enable = st_r.dac_b_en;
endmodule

// >>> txp_path_asserts.sv
// Concurrent checks on the transmit path ports, bound to the design.
`timescale 1ns/100ps
`include "txp_consts.svh"
module txp_path_asserts (
  input wire logic                  sys_clk,
  input wire logic                  resetn,
  input wire logic                  sample_latch_clock_a,
  input wire logic                  sample_latch_clock_b,
  input wire logic [`TXP_PIN_W-1:0] tx_data,
  input wire logic                  tx_data_is_b,
  input wire logic [3:0]            reg_addr,
  input wire logic [7:0]            reg_wr_data,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [7:0]            reg_rd_data,
  input wire txp_pkg::txp_sample_t  dac_a_data,
  input wire txp_pkg::txp_sample_t  dac_b_data,
  input wire logic                  dac_update,
  input wire logic                  dac_b_enable
);
  // Shadows of the interp, mode and DSP fields predict what reads must return.
  logic [1:0] interp_r;
  logic [4:0] mode_r;
  logic [7:0] dsp_r;
  logic       single;
  logic       x4;
  logic       hil;
  logic       iq;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      interp_r <= 2'h0;
      mode_r   <= 5'h08;
      dsp_r    <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == `TXP_REG_INTERP) interp_r <= reg_wr_data[1:0];
      if (reg_addr == `TXP_REG_MODE) mode_r <= reg_wr_data[4:0];
      if (reg_addr == `TXP_REG_DSP) dsp_r <= reg_wr_data;
    end
  end
  always_comb begin
    single = mode_r[1:0] == `TXP_MODE_SINGLE;
    x4     = interp_r == `TXP_INTERP_4X;
    hil    = single & dsp_r[0] & x4;
    iq     = hil | (mode_r[1:0] == `TXP_MODE_COMPLEX);
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_rd_at(logic [3:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_edge_1x;
    $rose(sample_latch_clock_a) && mode_r == 5'h08 && interp_r == 2'h0;
  endsequence
  property p_rd_idle;
    !reg_rd |=> reg_rd_data == 8'h00;
  endproperty
  property p_rd_unmapped;
    reg_rd && reg_addr[3] |=> reg_rd_data == 8'h00;
  endproperty
  property p_rd_dsp;
    s_rd_at(`TXP_REG_DSP) |=> reg_rd_data == dsp_r;
  endproperty
  property p_stat_hil;
    s_rd_at(`TXP_REG_STAT) |=> reg_rd_data[1:0] == {hil, single};
  endproperty
  property p_stat_mix;
    s_rd_at(`TXP_REG_STAT) |=> reg_rd_data[2] == (&dsp_r[3:2] & x4 & iq);
  endproperty
  property p_stat_coarse;
    s_rd_at(`TXP_REG_STAT) |=> reg_rd_data[4] == (iq & !dsp_r[7]);
  endproperty
  property p_b_enable;
    dac_b_enable == !$past(single);
  endproperty
  property p_b_quiet;
    !dac_b_enable [*3] ##0 dac_update |-> dac_b_data == 16'sh0000;
  endproperty
  property p_a_hold;
    $changed(dac_a_data) |-> dac_update;
  endproperty
  property p_1x_slot;
    s_edge_1x |-> ##[3:7] dac_update;
  endproperty
  a_rd_idle:     assert property (p_rd_idle)
    else $error("read data not zero outside a read reply");
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read returned nonzero");
  a_rd_dsp:      assert property (p_rd_dsp)
    else $error("control register readback differs");
  a_stat_hil:    assert property (p_stat_hil)
    else $error("hilbert status wrong");
  a_stat_mix:    assert property (p_stat_mix)
    else $error("oscillator mix status wrong");
  a_stat_coarse: assert property (p_stat_coarse)
    else $error("coarse complex status wrong");
  a_b_enable:    assert property (p_b_enable)
    else $error("channel b enable does not follow mode");
  a_b_quiet:     assert property (p_b_quiet)
    else $error("channel b data while powered down");
  a_a_hold:      assert property (p_a_hold)
    else $error("channel a data changed without update");
  a_1x_slot:     assert property (p_1x_slot)
    else $error("no bypass update after latch edge");
endmodule
bind txp_path txp_path_asserts u_chk (
  .sys_clk, .resetn, .sample_latch_clock_a, .sample_latch_clock_b,
  .tx_data, .tx_data_is_b, .reg_addr, .reg_wr_data, .reg_wr, .reg_rd,
  .reg_rd_data, .dac_a_data, .dac_b_data, .dac_update, .dac_b_enable
);

// >>> txp_pkg.sv
// Types shared by the transmit interpolation and modulation path.
`include "txp_consts.svh"
package txp_pkg;
  typedef logic signed [15:0] txp_sample_t;
  typedef struct packed {
    txp_sample_t i;
    txp_sample_t q;
  } txp_iq_s;
  typedef struct packed {
    logic [5:0] rsv;
    logic [1:0] interp;
  } txp_interp_reg_s;
  typedef struct packed {
    logic [2:0] rsv;
    logic       fall;
    logic       rise;
    logic       clk_b;
    logic [1:0] mode;
  } txp_mode_reg_s;
  typedef struct packed {
    logic       real_mix;
    logic       coarse_neg;
    logic [1:0] coarse;
    logic       fine_b;
    logic       fine_a;
    logic       sideband_select_low;
    logic       hilbert;
  } txp_dsp_reg_s;
  typedef struct packed {
    logic [2:0] rsv;
    logic       coarse_cplx;
    logic       iq;
    logic       fine_on;
    logic       hil_on;
    logic       single;
  } txp_stat_s;
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] mid;
    logic [7:0] lo;
  } txp_tw_s;
  typedef struct packed {
    logic [1:0] quad;
    logic [3:0] idx;
  } txp_phase_s;
  typedef struct packed {
    txp_phase_s  ph;
    logic [17:0] frac;
  } txp_acc_s;
  typedef enum logic {TXP_IDLE, TXP_RUN} txp_run_e;
  typedef struct packed {
    logic [1:0]                          lclk_m;
    logic [1:0]                          lclk_s;
    logic [1:0]                          lclk_d;
    logic [`TXP_PIN_W-1:0]               din_m;
    logic [`TXP_PIN_W-1:0]               din_s;
    logic                                selb_m;
    logic                                selb_s;
    txp_interp_reg_s                     interp_r;
    txp_mode_reg_s                       mode_r;
    txp_dsp_reg_s                        dsp_r;
    txp_tw_s                             nco_tuning_word;
    txp_sample_t                         hold_a;
    txp_sample_t [`TXP_HIL_TAPS-1:0]     hil;
    txp_sample_t [`TXP_FIR1_LEN-1:0]     hist1_i;
    txp_sample_t [`TXP_FIR1_LEN-1:0]     hist1_q;
    txp_sample_t [`TXP_FIR2_LEN-1:0]     hist2_i;
    txp_sample_t [`TXP_FIR2_LEN-1:0]     hist2_q;
    txp_acc_s                            acc;
    logic [`TXP_PER_W-1:0]               per_cnt;
    logic [`TXP_PER_W-1:0]               step;
    logic [`TXP_PER_W-1:0]               tmr;
    logic [1:0]                          slot;
    txp_run_e                            run;
    logic [2:0]                          cn;
    txp_sample_t                         dac_a;
    txp_sample_t                         dac_b;
    logic                                dac_upd;
    logic                                dac_b_en;
    logic [7:0]                          rd_data;
    logic [7:0]                          count;
  } txp_state_s;
endpackage

// >>> txp_src_model.sv
// Baseband source model driving the latch clock and sample words.
`timescale 1ns/100ps
`include "txp_consts.svh"
module txp_src_model #(
  parameter real HALF_NS = 62.5
) (
  input  wire logic                  run,
  input  wire logic                  use_b,
  input  wire logic                  dual,
  input  wire logic [`TXP_PIN_W-1:0] word_a,
  input  wire logic [`TXP_PIN_W-1:0] word_b,
  output logic                       clk_a,
  output logic                       clk_b,
  output logic [`TXP_PIN_W-1:0]      data,
  output logic                       is_b
);
  // Words change on the falling edge, so each is steady for a full period
  // around the capturing edge; the clock stands low while run is low.
  initial begin
    clk_a = 1'b0;
    clk_b = 1'b0;
    data  = '0;
    is_b  = 1'b0;
    forever begin
      wait (run);
      #(HALF_NS);
      if (use_b) clk_b = 1'b1;
      else clk_a = 1'b1;
      #(HALF_NS);
      clk_a = 1'b0;
      clk_b = 1'b0;
      is_b  = dual && !is_b;
      data  = is_b ? word_b : word_a;
    end
  end
endmodule
